// File: bench/wsch_relay_model.sv
// Purpose: relay sequencer stand-in facing the command handler
// Assumes: one clock, synchronous active-low reset
// Notes:   busy two cycles after each advance or while held by the bench
`timescale 1ns/1ps
module wsch_relay_model #(
   parameter int SCAN_LEN = 4
) (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       relay_advance,
   input  wire logic       hold,
   input  wire logic       fault_in,
   output logic            relay_busy,
   output logic            scan_done,
   output logic            relay_fault,
   output logic [7:0]      adv_cnt
);
   logic [1:0] busy_q;

   // count closures, settle time after each, pass done at list end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy_q <= 2'h0;
         adv_cnt <= 8'h00;
         scan_done <= 1'b0;
      end else begin
         busy_q <= relay_advance ? 2'h2 : (busy_q != 2'h0 ? busy_q - 2'h1 : 2'h0);
         adv_cnt <= adv_cnt + 8'(relay_advance);
         scan_done <= relay_advance && (32'(adv_cnt) % SCAN_LEN == SCAN_LEN - 1);
      end
   end

   assign relay_busy = hold | (busy_q != 2'h0);
   assign relay_fault = fault_in;
endmodule

// File: bench/wsch_top_tb_top.sv
// Purpose: self-checking bench for the command handler
// Assumes: register map and opcodes of the package
// Notes:   every scenario task judges its own results
`timescale 1ns/1ps
module wsch_top_tb_top;
   import wsch_pkg::*;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, bresp_seen, rresp_seen;
   logic [31:0] rdata, d;
   logic        busy, done, fault, adv, cbv;
   logic        hold = 1'b0, fault_in = 1'b0;
   logic [3:0]  wstrb = 4'hF;
   logic [7:0]  cb, adv_cnt, n0, byte_seen;
   int          mismatches = 0, num_checks = 0, nvalid = 0;

   always #25 aclk = ~aclk;

   wsch_top wsch_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .relay_busy(busy), .scan_done(done), .relay_fault(fault),
      .relay_advance(adv), .cmd_byte(cb), .cmd_byte_valid(cbv));

   wsch_relay_model wsch_relay_model_inst (.aclk(aclk), .aresetn(aresetn),
      .relay_advance(adv), .hold(hold), .fault_in(fault_in), .relay_busy(busy),
      .scan_done(done), .relay_fault(fault), .adv_cnt(adv_cnt));

   // capture delivered command bytes
   always @(posedge aclk) begin
      if (cbv === 1'b1) begin
         nvalid++;
         byte_seen = cb;
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bresp_seen = bresp;
      bready <= 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      v = rdata;
      rresp_seen = rresp;
      rready <= 1'b0;
   endtask

   // command then room for a reply of up to three digits
   task cmd(input logic [7:0] op, input logic [7:0] arg);
      wr(OFS_CMD, {16'h0000, arg, op});
      repeat (6) @(posedge aclk);
   endtask

   task pop(input logic [7:0] exp);
      rd(OFS_RESP, d);
      chk(32'(d[RSP_DOR]), 1);
      cmd(OP_BREQ, 8'h00);
      rd(OFS_RESP, d);
      chk(32'(d[15:8]), 32'(exp));
   endtask

   task t_regs;
      rd(OFS_STAT, d);
      chk(d, 0);
      rd(OFS_RESP, d);
      chk(d, 0);
      rd(OFS_SCAN, d);
      chk(d, 0);
      rd(8'h10, d);
      chk(32'(rresp_seen), 32'(RESP_ERR));
      wr(8'h10, 32'h0);
      chk(32'(bresp_seen), 32'(RESP_ERR));
      // command write without the low byte lanes is ignored
      wstrb <= 4'hC;
      wr(OFS_CMD, {24'h000000, OP_SETLK});
      wstrb <= 4'hF;
      chk(32'(bresp_seen), 32'(RESP_OK));
      rd(OFS_CMD, d);
      chk(d, 0);
      rd(OFS_RESP, d);
      chk(32'(d[RSP_LOCK]), 0);
   endtask

   task t_ops;
      cmd(OP_BNO, 8'h00);
      cmd(OP_BNO, 8'h00);
      rd(OFS_RESP, d);
      chk(32'(d[1:0]), 1);
      cmd(OP_SETLK, 8'h00);
      rd(OFS_RESP, d);
      chk(32'(d[1:0]), 3);
      cmd(OP_CLRLK, 8'h00);
      rd(OFS_RESP, d);
      chk(32'(d[1:0]), 1);
      cmd(OP_RDPRT, 8'h00);
      rd(OFS_RESP, d);
      chk(32'(d[15:8]), 32'h5A);
      nvalid = 0;
      cmd(OP_BAV, 8'hAB);
      chk(32'(byte_seen), 32'hAB);
      chk(nvalid, 1);
   endtask

   task t_queue;
      cmd(OP_ESE, 8'h25);
      cmd(OP_SRE, 8'h10);
      rd(OFS_STAT, d);
      chk(32'(d[31:16]), 32'h1025);
      cmd(OP_ESEQ, 8'h00);
      cmd(OP_SREQ, 8'h00);
      rd(OFS_STAT, d);
      chk(32'(d[STB_MAV]), 1);
      pop(8'h33);
      pop(8'h37);
      pop(8'h31);
      pop(8'h36);
      rd(OFS_STAT, d);
      chk(32'(d[STB_MAV]), 0);
   endtask

   task t_err;
      cmd(OP_CLS, 8'h00);
      cmd(OP_ESYN, 8'h00);
      cmd(OP_ERNG, 8'h00);
      rd(OFS_STAT, d);
      chk(32'(d[15:8]), 32'h30);
      chk(32'(d[STB_EAV]), 1);
      cmd(OP_RDSTB, 8'h00);
      rd(OFS_RESP, d);
      chk(32'(d[15:8]), 32'h24);
      cmd(OP_ESRQ, 8'h00);
      pop(8'h34);
      pop(8'h38);
      rd(OFS_STAT, d);
      chk(32'(d[15:8]), 0);
      cmd(OP_CLS, 8'h00);
      rd(OFS_SCAN, d);
      chk(32'(d[7:4]), 0);
      rd(OFS_STAT, d);
      chk(32'(d[15:0]), 0);
      cmd(OP_STBQ, 8'h00);
      pop(8'h30);
   endtask

   task t_opc;
      hold <= 1'b1;
      cmd(OP_OPCQ, 8'h00);
      rd(OFS_STAT, d);
      chk(32'(d[STB_MAV]), 0);
      hold <= 1'b0;
      repeat (6) @(posedge aclk);
      pop(8'h31);
      hold <= 1'b1;
      cmd(OP_OPC, 8'h00);
      rd(OFS_STAT, d);
      chk(32'(d[8 + ESR_OPC]), 0);
      hold <= 1'b0;
      repeat (6) @(posedge aclk);
      rd(OFS_STAT, d);
      chk(32'(d[8 + ESR_OPC]), 1);
      hold <= 1'b1;
      cmd(OP_WAI, 8'h00);
      fork
         wr(OFS_CMD, {24'h0, OP_SETLK});
      join_none
      repeat (10) @(posedge aclk);
      rd(OFS_RESP, d);
      chk(32'(d[RSP_LOCK]), 0);
      hold <= 1'b0;
      repeat (12) @(posedge aclk);
      rd(OFS_RESP, d);
      chk(32'(d[RSP_LOCK]), 1);
   endtask

   task t_trig;
      cmd(OP_TSRC, 8'h01);
      cmd(OP_INIT1, 8'h00);
      rd(OFS_SCAN, d);
      chk(32'(d[2:0]), 5);
      n0 = adv_cnt;
      cmd(OP_TRIG, 8'h00);
      cmd(OP_TRG, 8'h00);
      chk(32'(adv_cnt - n0), 2);
      cmd(OP_ESEQ, 8'h00);
      cmd(OP_CLR, 8'h00);
      rd(OFS_STAT, d);
      chk(32'(d[STB_MAV]), 0);
      rd(OFS_SCAN, d);
      chk(32'(d[0]), 1);
      cmd(OP_ABORT, 8'h00);
      rd(OFS_SCAN, d);
      chk(32'(d[0]), 0);
      cmd(OP_TRIG, 8'h00);
      chk(32'(adv_cnt - n0), 2);
      cmd(OP_INITC, 8'h00);
      rd(OFS_SCAN, d);
      chk(32'(d[1:0]), 3);
      cmd(OP_RST, 8'h00);
      rd(OFS_SCAN, d);
      chk(32'(d[3:0]), 0);
      rd(OFS_STAT, d);
      chk(32'(d[23:16]), 32'h25);
   endtask

   task t_tst;
      cmd(OP_TSTQ, 8'h00);
      pop(8'h30);
      fault_in <= 1'b1;
      cmd(OP_TSTQ, 8'h00);
      pop(8'h31);
   endtask

   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // main sequence after a four-cycle reset
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_ops;
      t_queue;
      t_err;
      t_opc;
      t_trig;
      t_tst;
      report_and_stop;
   end

   // cut a hang short
   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      report_and_stop;
   end
endmodule

// File: hdl/wsch_fifo.sv
// Purpose: reply byte queue, first in first out
// Assumes: one clock, synchronous active-low reset
// Notes:   flush wins over a push in the same cycle
`timescale 1ns/1ps
module wsch_fifo
   import wsch_pkg::*;
#(
   parameter int W  = 8,
   parameter int D  = OQ_DEPTH,
   parameter int AW = OQ_AW
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         flush,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   logic [W-1:0] mem_q [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   // handshake terms
   assign in_ready  = (cnt_q != (AW+1)'(D));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rp_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // storage
   always_ff @(posedge aclk) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end

   // pointers and fill count
   always_ff @(posedge aclk) begin
      if (!aresetn || flush) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// File: hdl/wsch_pkg.sv
// Purpose: shared constants and types for the word-serial status command handler
// Assumes: AXI4-Lite register access, one 20 MHz clock
// Notes:   opcode values are carried in the low byte of the command register
package wsch_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_CMD  = 8'h00;
   localparam logic [7:0] OFS_RESP = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_SCAN = 8'h0C;

   // status byte bit positions
   localparam int STB_EAV = 2;
   localparam int STB_MAV = 4;
   localparam int STB_ESB = 5;
   localparam int STB_MSS = 6;

   // standard event status bit positions
   localparam int ESR_OPC = 0;
   localparam int ESR_EXE = 4;
   localparam int ESR_CME = 5;

   // response register bit positions
   localparam int RSP_RUN  = 0;
   localparam int RSP_LOCK = 1;
   localparam int RSP_DOR  = 2;
   localparam int RSP_BUSY = 3;

   // reset values and limits
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [3:0] ERR_MAX   = 4'hF;
   localparam logic [7:0] ASCII_0   = 8'h30;
   localparam logic [7:0] DEC_100   = 8'h64;
   localparam logic [7:0] DEC_10    = 8'h0A;
   localparam logic [1:0] RESP_OK   = 2'h0;
   localparam logic [1:0] RESP_ERR  = 2'h2;
   localparam int         OQ_DEPTH  = 8;
   localparam int         OQ_AW     = 3;

   // command opcodes
   typedef enum logic [7:0] {
      OP_BNO    = 8'h01, OP_BAV   = 8'h02, OP_BREQ  = 8'h03, OP_CLR  = 8'h04,
      OP_CLRLK  = 8'h05, OP_SETLK = 8'h06, OP_RDPRT = 8'h07, OP_RDSTB = 8'h08,
      OP_TRIG   = 8'h09, OP_CLS   = 8'h10, OP_ESE   = 8'h11, OP_ESEQ = 8'h12,
      OP_ESRQ   = 8'h13, OP_OPC   = 8'h14, OP_OPCQ  = 8'h15, OP_RST  = 8'h16,
      OP_SRE    = 8'h17, OP_SREQ  = 8'h18, OP_STBQ  = 8'h19, OP_TRG  = 8'h1A,
      OP_TSTQ   = 8'h1B, OP_WAI   = 8'h1C, OP_ABORT = 8'h20, OP_INIT1 = 8'h21,
      OP_INITC  = 8'h22, OP_TSRC  = 8'h23, OP_ESYN  = 8'h30, OP_ERNG = 8'h31
   } wsch_op_t;

   // command word as written by software
   typedef struct packed {
      logic [7:0] arg;
      logic [7:0] op;
   } wsch_cmd_t;

   // decimal reply formatter states, gray along the path
   typedef enum logic [1:0] {
      DS_IDLE = 2'b00,
      DS_HUN  = 2'b01,
      DS_TEN  = 2'b11,
      DS_ONE  = 2'b10
   } wsch_ds_t;

endpackage

// File: hdl/wsch_top.sv
// Purpose: word-serial command handler with 488.2 status model
// Assumes: AXI4-Lite slave, relay sequencer reports busy, scan end and fault
// Notes:   one write and one read outstanding; query replies leave via the queue
//
// Summary of operation
// - begin-normal-operation starts the block; repeats change nothing.
// - byte-available passes its data byte to the command input path.
// - byte request pops the queue head into the reply byte.
// - clear resets the interface and pending work; relays keep running.
// - set-lock sets the lock bit, clear-lock clears it.
// - read-protocol returns the protocol descriptor.
// - read-status-byte returns the current status byte.
// - with bus trigger source, a trigger advances the armed scan.
// - clear-status zeroes events, error count and output queue.
// - event enable is written by command and reported in decimal.
// - event status query reports in decimal then zeroes the register.
// - operation-complete sets event bit 0 once relays are idle.
// - operation-complete query queues ASCII 1 once relays are idle.
// - reset command restores power-up scan state, keeping status registers.
// - service request enable is written by command and reported in decimal.
// - status byte query reports the status byte in decimal.
// - common trigger behaves exactly like the word-serial trigger.
// - self-test query queues ASCII 0 on pass, 1 on fault.
// - after wait-to-continue, only clear executes until relays are idle.
// - abort returns an armed scan to idle.
// - initiate arms the scan for one pass or continuously.
// - non-empty output queue sets status bit 4 and data-out-ready.
// - pending errors keep status byte bit 2 set.
// - syntax error sets event bit 5; range error sets bit 4.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module wsch_top
   import wsch_pkg::*;
#(
   parameter logic [7:0] PROTOCOL = 8'h5A  // arbitrary descriptor value
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   input  wire logic        relay_busy,
   input  wire logic        scan_done,
   input  wire logic        relay_fault,
   output logic             relay_advance,
   output logic [7:0]       cmd_byte,
   output logic             cmd_byte_valid
);
   logic        aw_q, w_q, bvalid_q, awready_q, wready_q, arready_q, rvalid_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0]  wstrb_q;
   logic [1:0]  bresp_q, rresp_q;
   wsch_cmd_t   cmd_q;
   logic        cmd_v_q;
   logic        run_q, lock_q, wai_q, opc_q, opcq_q;
   logic        armed_q, cont_q, bus_src_q, adv_q, byte_v_q;
   logic [7:0]  esr_q, esr_d, ese_q, sre_q, reply_q, byte_q;
   logic [3:0]  err_q, err_d;
   logic [7:0]  stb;
   wsch_ds_t    ds_q;
   logic [7:0]  dv_q, dv_d, dig_h, dig_t, dig_o;
   logic        oq_in_valid, oq_in_ready, oq_out_valid, oq_out_ready;
   logic [7:0]  oq_in_data, oq_out_data;
   logic        hit_cmd, wr_go, exec, is_clr, opcq_fire, ds_load, flush;
   logic        err_syn, err_rng;
   wsch_op_t    op;

   assign op = wsch_op_t'(cmd_q.op);

   // outputs straight from flops
   assign s_axi_awready  = awready_q;
   assign s_axi_wready   = wready_q;
   assign s_axi_bvalid   = bvalid_q;
   assign s_axi_bresp    = bresp_q;
   assign s_axi_arready  = arready_q;
   assign s_axi_rvalid   = rvalid_q;
   assign s_axi_rdata    = rdata_q;
   assign s_axi_rresp    = rresp_q;
   assign relay_advance  = adv_q;
   assign cmd_byte       = byte_q;
   assign cmd_byte_valid = byte_v_q;

   // status byte summary
   // queue bit set
   always_comb begin
      stb          = RST_BYTE;
      stb[STB_EAV] = (err_q != '0);
      stb[STB_MAV] = oq_out_valid;
      stb[STB_ESB] = |(esr_q & ese_q);
      stb[STB_MSS] = |(stb & sre_q);
   end

   // write decode; a command write waits while the latch is full
   assign hit_cmd = (awaddr_q == OFS_CMD);
   assign wr_go   = aw_q && w_q && !bvalid_q && !(hit_cmd && cmd_v_q);

   // write channel handling
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q      <= 1'b0;
         w_q       <= 1'b0;
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OK;
         awaddr_q  <= RST_BYTE;
         wdata_q   <= '0;
         wstrb_q   <= '0;
      end else begin
         if (s_axi_awvalid && awready_q) begin
            aw_q      <= 1'b1;
            awready_q <= 1'b0;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_q) begin
            w_q      <= 1'b1;
            wready_q <= 1'b0;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (awaddr_q > OFS_SCAN || awaddr_q[1:0] != 2'h0) ? RESP_ERR : RESP_OK;
         end
         if (bvalid_q && s_axi_bready) begin
            bvalid_q  <= 1'b0;
            aw_q      <= 1'b0;
            w_q       <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // read channel handling, answer one cycle after address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= RESP_OK;
      end else if (s_axi_arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rresp_q   <= RESP_OK;
         case (s_axi_araddr)
            OFS_CMD:  rdata_q <= {15'h0000, cmd_v_q, cmd_q};
            OFS_RESP: rdata_q <= {16'h0000, reply_q, 4'h0, (ds_q != DS_IDLE) || cmd_v_q,
                                  oq_out_valid, lock_q, run_q};
            OFS_STAT: rdata_q <= {sre_q, ese_q, esr_q, stb};
            OFS_SCAN: rdata_q <= {24'h000000, err_q, wai_q, bus_src_q, cont_q, armed_q};
            default: begin
               rdata_q <= '0;
               rresp_q <= RESP_ERR;
            end
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // execution gating
   // hold while waiting
   assign is_clr    = (op == OP_CLR);
   assign opcq_fire = opcq_q && !relay_busy && (ds_q == DS_IDLE);
   assign exec      = cmd_v_q && (is_clr || ((ds_q == DS_IDLE) && !opcq_fire
                                              && !(wai_q && relay_busy)));
   assign oq_out_ready = exec && (op == OP_BREQ);
   assign flush   = exec && (is_clr || op == OP_CLS);
   assign err_syn = exec && (op == OP_ESYN);
   assign err_rng = exec && (op == OP_ERNG);

   // command latch
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_v_q <= 1'b0;
         cmd_q   <= '0;
      end else if (wr_go && hit_cmd && wstrb_q[1:0] == 2'h3) begin
         cmd_v_q <= 1'b1;
         cmd_q   <= wdata_q[15:0];
      end else if (exec) begin
         cmd_v_q <= 1'b0;
      end
   end

   // event status next value; a set in the clearing cycle wins
   always_comb begin
      esr_d = esr_q;
      if (exec && (op == OP_ESRQ || op == OP_CLS)) begin
         esr_d = RST_BYTE;
      end
      if (opc_q && !relay_busy) begin
         esr_d[ESR_OPC] = 1'b1;
      end
      if (err_rng) begin
         esr_d[ESR_EXE] = 1'b1;
      end
      if (err_syn) begin
         esr_d[ESR_CME] = 1'b1;
      end
      err_d = (exec && op == OP_CLS) ? 4'h0 : err_q;
      if ((err_syn || err_rng) && err_d != ERR_MAX) begin
         err_d = err_d + 4'h1;
      end
   end

   // status registers, lock and operating state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         esr_q <= RST_BYTE;
         ese_q <= RST_BYTE;
         sre_q <= RST_BYTE;
         err_q <= '0;
         run_q <= 1'b0;
         lock_q <= 1'b0;
         reply_q <= RST_BYTE;
      end else begin
         esr_q <= esr_d;
         err_q <= err_d;
         if (exec) begin
            case (op)
               OP_BNO:   run_q <= 1'b1;
               OP_SETLK: lock_q <= 1'b1;
               OP_CLRLK: lock_q <= 1'b0;
               OP_BREQ:  reply_q <= oq_out_valid ? oq_out_data : RST_BYTE;
               OP_RDPRT: reply_q <= PROTOCOL;
               OP_RDSTB: reply_q <= stb;
               OP_ESE:   ese_q <= cmd_q.arg;
               OP_SRE:   sre_q <= cmd_q.arg;
               default:  reply_q <= reply_q;
            endcase
         end
      end
   end

   // pending-operation flags and scan sequencing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wai_q <= 1'b0;
         opc_q <= 1'b0;
         opcq_q <= 1'b0;
         armed_q <= 1'b0;
         cont_q <= 1'b0;
         bus_src_q <= 1'b0;
         adv_q <= 1'b0;
         byte_q <= RST_BYTE;
         byte_v_q <= 1'b0;
      end else begin
         adv_q <= 1'b0;
         byte_v_q <= 1'b0;
         if (wai_q && !relay_busy) begin
            wai_q <= 1'b0;
         end
         if (opc_q && !relay_busy) begin
            opc_q <= 1'b0;
         end
         if (opcq_fire) begin
            opcq_q <= 1'b0;
         end
         if (scan_done && !cont_q) begin
            armed_q <= 1'b0;
         end
         if (exec) begin
            case (op)
               OP_BAV: begin
                  byte_q <= cmd_q.arg;
                  byte_v_q <= 1'b1;
               end
               OP_CLR: begin
                  wai_q <= 1'b0;
                  opc_q <= 1'b0;
                  opcq_q <= 1'b0;
               end
               OP_TRIG, OP_TRG: adv_q <= armed_q && bus_src_q;
               OP_OPC:  opc_q <= 1'b1;
               OP_OPCQ: opcq_q <= 1'b1;
               OP_WAI:  wai_q <= 1'b1;
               OP_RST: begin
                  armed_q <= 1'b0;
                  cont_q <= 1'b0;
                  bus_src_q <= 1'b0;
                  wai_q <= 1'b0;
                  opc_q <= 1'b0;
                  opcq_q <= 1'b0;
               end
               OP_ABORT: armed_q <= 1'b0;
               OP_INIT1: begin
                  armed_q <= 1'b1;
                  cont_q <= 1'b0;
               end
               OP_INITC: begin
                  armed_q <= 1'b1;
                  cont_q <= 1'b1;
               end
               OP_TSRC: bus_src_q <= cmd_q.arg[0];
               default: adv_q <= 1'b0;
            endcase
         end
      end
   end

   // decimal formatter load and value select
   always_comb begin
      ds_load = opcq_fire;
      dv_d = 8'h01;
      if (exec && !opcq_fire) begin
         ds_load = 1'b1;
         case (op)
            OP_ESEQ: dv_d = ese_q;
            OP_ESRQ: dv_d = esr_q;
            OP_SREQ: dv_d = sre_q;
            OP_STBQ: dv_d = stb;
            OP_TSTQ: dv_d = {7'h00, relay_fault};
            default: ds_load = 1'b0;
         endcase
      end
   end

   // digits; leading zeros are skipped
   assign dig_h = dv_q / DEC_100;
   assign dig_t = (dv_q / DEC_10) % DEC_10;
   assign dig_o = dv_q % DEC_10;
   assign oq_in_valid = (ds_q == DS_HUN && dig_h != '0) || (ds_q == DS_ONE)
                     || (ds_q == DS_TEN && (dig_h != '0 || dig_t != '0));
   always_comb begin
      case (ds_q)
         DS_HUN:  oq_in_data = ASCII_0 + dig_h;
         DS_TEN:  oq_in_data = ASCII_0 + dig_t;
         default: oq_in_data = ASCII_0 + dig_o;
      endcase
   end

   // formatter sequence; stalls on a full queue
   // decimal report
   always_ff @(posedge aclk) begin
      if (!aresetn || flush) begin
         ds_q <= DS_IDLE;
         dv_q <= RST_BYTE;
      end else if (ds_load) begin
         ds_q <= DS_HUN;
         dv_q <= dv_d;
      end else if (!oq_in_valid || oq_in_ready) begin
         case (ds_q)
            DS_HUN:  ds_q <= DS_TEN;
            DS_TEN:  ds_q <= DS_ONE;
            default: ds_q <= DS_IDLE;
         endcase
      end
   end

   wsch_fifo #(.W(8), .D(OQ_DEPTH), .AW(OQ_AW)) u_oq (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .flush     (flush),
      .in_valid  (oq_in_valid),
      .in_ready  (oq_in_ready),
      .in_data   (oq_in_data),
      .out_valid (oq_out_valid),
      .out_ready (oq_out_ready),
      .out_data  (oq_out_data)
   );

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_opcq_fire;
      opcq_q && !relay_busy && ds_q == DS_IDLE;
   endsequence
   sequence s_one_out;
      ds_q == DS_ONE && oq_in_valid && oq_in_data == 8'h31;
   endsequence

   a_run_sticky: assert property (run_q |=> run_q)
      else $error("operating state dropped");
   a_lock_set: assert property (exec && op == OP_SETLK |=> lock_q)
      else $error("lock not set");
   a_breq_head: assert property (oq_out_ready && oq_out_valid
                                 |=> reply_q == $past(oq_out_data))
      else $error("reply is not queue head");
   a_esr_zeroed: assert property (exec && op == OP_ESRQ
                                  |=> (esr_q & 8'hFE) == 8'h00)
      else $error("event status not zeroed");
   a_opc_bit: assert property (opc_q && !relay_busy |=> esr_q[ESR_OPC])
      else $error("completion bit missing");
   a_opcq_one: assert property (s_opcq_fire |=> ##2 s_one_out)
      else $error("ASCII 1 not produced");
   a_wai_hold: assert property (wai_q && relay_busy && !is_clr |-> !exec)
      else $error("command ran while waiting");
   a_trig_adv: assert property (exec && (op == OP_TRIG || op == OP_TRG)
                                && armed_q && bus_src_q |=> relay_advance)
      else $error("trigger did not advance");
   a_abort_idle: assert property (exec && op == OP_ABORT |=> !armed_q)
      else $error("scan still armed");
   a_cls_empty: assert property (exec && op == OP_CLS
                                 |=> err_q == 4'h0 && !oq_out_valid)
      else $error("clear status incomplete");
   a_syn_err: assert property (err_syn |=> esr_q[ESR_CME] && err_q != 4'h0)
      else $error("syntax error not recorded");
endmodule
